// [verilog/amsc_pkg.sv]
// amsc_pkg: shared constants and types of the converter mode controller
// assumes a single 100 MHz clock domain and a plain register port
package amsc_pkg;

	// ------------------------------------------------------------
	// register map (word offsets on the plain port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL_REG_A = 4'h0;
	localparam logic [3:0] ADDR_COMMAND       = 4'h1;
	localparam logic [3:0] ADDR_STATUS        = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STATUS    = 4'h3;
	localparam logic [3:0] ADDR_IRQ_MASK      = 4'h4;
	localparam logic [3:0] ADDR_RESULT        = 4'h5;
	localparam logic [3:0] ADDR_INTERVAL      = 4'h6;

	// ------------------------------------------------------------
	// control_reg_a fields
	// ------------------------------------------------------------
	localparam int PD_LSB        = 0;
	localparam int CONT_ALIGN_BIT = 2;
	localparam logic [1:0] PD_SLEEP   = 2'h1;
	localparam logic [1:0] PD_STANDBY = 2'h2;
	localparam logic [7:0] CONTROL_RESET = 8'h02;

	// ------------------------------------------------------------
	// command byte fields
	// ------------------------------------------------------------
	localparam int CMD_CONVERT_BIT   = 0;
	localparam int CMD_POWERDOWN_BIT = 1;
	localparam int CMD_CALIBRATE_BIT = 2;
	localparam int CMD_RESET_BIT     = 3;

	// ------------------------------------------------------------
	// interrupt bits
	// ------------------------------------------------------------
	localparam int IRQ_RESULT  = 0;
	localparam int IRQ_RESTART = 1;
	localparam int IRQ_CAL_END = 2;
	localparam int IRQ_ABORT   = 3;
	localparam int IRQ_W       = 4;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int CONV_TIME_US    = 125;
	localparam int CONV_CYCLES     = CONV_TIME_US * CLK_MHZ;
	localparam int CAL_TIME_US     = 200;
	localparam int CAL_CYCLES      = CAL_TIME_US * CLK_MHZ;
	localparam logic [7:0] ALIGN_TOL = 8'h01;
	localparam int CNT_W           = 24;

	typedef enum logic [1:0] {
		AMSC_STANDBY,
		AMSC_SLEEP,
		AMSC_CAL,
		AMSC_CONV
	} amsc_state_e;

endpackage

// [verilog/amsc_edge_detect.sv]
// amsc_edge_detect: rising-edge pulse of a synchronous level
// assumes the input is already synchronous to clk
`timescale 1ns/1ps
module amsc_edge_detect
	import amsc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level,
	output logic      rise
);
	logic prev;

	// remember last sample
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end

	assign rise = level & ~prev;
endmodule // amsc_edge_detect

// [verilog/amsc_interval_cmp.sv]
// amsc_interval_cmp: compares a measured edge interval with a reference
// assumes both counts are in master-clock cycles
`timescale 1ns/1ps
module amsc_interval_cmp
	import amsc_pkg::*;
(
	input  wire logic [CNT_W-1:0] measured,
	input  wire logic [CNT_W-1:0] reference,
	output logic                  off_limit
);
	logic [CNT_W-1:0] diff;

	// absolute difference against the tolerance
	always_comb begin
		diff = (measured >= reference) ? (measured - reference)
		                               : (reference - measured);
		off_limit = (diff > CNT_W'(ALIGN_TOL)); // R4
	end
endmodule // amsc_interval_cmp

// [verilog/amsc_mode_ctrl.sv]
// amsc_mode_ctrl: operating-state controller of a delta-sigma converter
// assumes a host on a plain register port and an align request pin or
// serial align command, all synchronous to the 100 MHz master clock
// the serial framing is outside this block: a command arrives here as one
// write of the command word, and the serial align request is bit 4 of it
// limitation: conversion and calibration lengths are fixed package
// constants, so a result takes a fixed number of master-clock cycles
//
// Notes on behaviour
// [R1] align ignored in standby or calibration; a serial align still ends calibration as a command write
// [R2] pulse mode: align restarts running conversion; a serial align ends it as a command write instead
// [R3] continuous mode: first edge loads interval reference
// [R4] later edges restart only beyond one count
// [R5] edges before first result are ignored
// [R6] after first result every edge is evaluated
// [R7] command write in standby stays standby
// [R8] command write in sleep stays sleep
// [R9] command write ends calibration into standby
// [R10] command write ends conversion into standby
// [R11] convert leaves standby and starts converting
// [R12] convert leaves sleep and starts converting
// [R13] convert aborts calibration, starts conversion
// [R14] convert aborts conversion, starts fresh one
// [R15] powerdown select: 01 sleep, 10 standby
// [R16] reset stops activity, standby, defaults
// [R17] result ready low until result read
// [R18] align mode held in host setting
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module amsc_mode_ctrl
	import amsc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        reset_pin_n,
	input  wire logic        align_pin,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic [23:0] sample_data,
	output logic             result_ready_n,
	output logic             low_power_idle,
	output logic             converting,
	output logic             calibrating,
	output logic             irq
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	// state and configuration
	amsc_state_e      state;
	amsc_state_e      next_state;
	logic [7:0]       control_reg_a;
	logic [1:0]       powerdown_select;
	logic             cont_align;
	// interrupt and result registers
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [23:0]      result;
	// cycle counters and alignment tracking
	logic [CNT_W-1:0] phase_cnt;
	logic [CNT_W-1:0] edge_cnt;
	logic [CNT_W-1:0] interval_ref;
	logic             ref_valid;
	logic             first_result_seen;
	// per-cycle events and decoded strobes
	logic             align_soft;
	logic             align_rise;
	logic             off_limit;
	logic             wr_control;
	logic             wr_command;
	logic             cmd_convert;
	logic             cmd_powerdown;
	logic             cmd_calibrate;
	logic             cmd_reset;
	logic             soft_reset;
	logic             align_eval;
	logic             restart;
	logic             conv_done;
	logic             cal_done;
	logic             result_read;
	logic             aborted;
	logic [IRQ_W-1:0] irq_events;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic is_write(input logic [3:0] a);
		is_write = reg_wr && (reg_addr == a);
	endfunction

	// register writes
	assign wr_control    = is_write(ADDR_CONTROL_REG_A);
	assign wr_command    = is_write(ADDR_COMMAND);

	// command bits, each qualified by a command write
	assign cmd_convert   = wr_command && reg_wdata[CMD_CONVERT_BIT];
	assign cmd_powerdown = wr_command && reg_wdata[CMD_POWERDOWN_BIT];
	assign cmd_calibrate = wr_command && reg_wdata[CMD_CALIBRATE_BIT];
	assign cmd_reset     = wr_command && reg_wdata[CMD_RESET_BIT];

	// pin and serial resets act alike
	assign soft_reset    = !reset_pin_n || cmd_reset; // R16

	// a read of the result releases the ready flag
	assign result_read   = reg_rd && (reg_addr == ADDR_RESULT);

	// configuration fields
	assign powerdown_select = control_reg_a[PD_LSB +: 2];
	assign cont_align    = control_reg_a[CONT_ALIGN_BIT]; // R18

	// serial align request rides in bit 4 of the command word
	assign align_soft    = wr_command && reg_wdata[CMD_CONVERT_BIT+4];

	// ------------------------------------------------------------
	// align edge detection and interval compare
	// ------------------------------------------------------------
	amsc_edge_detect u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.level (align_pin),
		.rise  (align_rise)
	);

	amsc_interval_cmp u_cmp (
		.measured  (edge_cnt),
		.reference (interval_ref),
		.off_limit (off_limit)
	);

	// an align event is either a pin edge or the serial align command
	// outside conversion a pin edge changes nothing; the serial align is itself a command write, so
	// the state machine ends calibration or conversion on it as on any other command write
	always_comb begin
		align_eval = 1'b0;
		restart    = 1'b0;
		if ((align_rise || align_soft) && state == AMSC_CONV) begin // R1
			if (!cont_align) begin
				restart = 1'b1; // R2
			end else if (first_result_seen) begin // R5 R6
				align_eval = 1'b1;
				restart    = ref_valid && off_limit; // R4
			end
		end
	end

	assign conv_done = (state == AMSC_CONV) &&
	                   (phase_cnt == CNT_W'(CONV_CYCLES - 1));
	assign cal_done  = (state == AMSC_CAL) &&
	                   (phase_cnt == CNT_W'(CAL_CYCLES - 1));

	// ------------------------------------------------------------
	// state transitions
	// ------------------------------------------------------------
	// priority: reset, then convert, then calibrate, then powerdown, then
	// any other command write; calibration ends in standby
	always_comb begin
		next_state = state;
		unique case (state)
			AMSC_STANDBY: begin
				if (cmd_convert) begin
					next_state = AMSC_CONV; // R11
				end else if (cmd_calibrate) begin
					next_state = AMSC_CAL;
				end else if (cmd_powerdown &&
				             powerdown_select == PD_SLEEP) begin
					next_state = AMSC_SLEEP; // R15
				end else begin
					next_state = AMSC_STANDBY; // R7
				end
			end
			AMSC_SLEEP: begin
				if (cmd_convert) begin
					next_state = AMSC_CONV; // R12
				end else if (cmd_powerdown &&
				             powerdown_select == PD_STANDBY) begin
					next_state = AMSC_STANDBY; // R15
				end else begin
					next_state = AMSC_SLEEP; // R8
				end
			end
			AMSC_CAL: begin
				if (cmd_convert) begin
					next_state = AMSC_CONV; // R13
				end else if (wr_command) begin
					next_state = AMSC_STANDBY; // R9
				end else if (cal_done) begin
					next_state = AMSC_STANDBY;
				end
			end
			AMSC_CONV: begin
				if (cmd_convert) begin
					next_state = AMSC_CONV; // R14
				end else if (cmd_powerdown &&
				             powerdown_select == PD_SLEEP) begin
					next_state = AMSC_SLEEP; // R15
				end else if (wr_command) begin
					next_state = AMSC_STANDBY; // R10
				end
			end
		endcase
		if (soft_reset) begin
			next_state = AMSC_STANDBY; // R16
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= AMSC_STANDBY;
		end else begin
			state <= next_state;
		end
	end

	// phase counter: restarts on every entry, abort and align restart
	// a convert in conversion keeps the state, so it is listed on its own
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_cnt <= '0;
		end else if (next_state != state || cmd_convert || restart ||
		             conv_done || cal_done || soft_reset) begin
			phase_cnt <= '0; // R2 R13 R14
		end else if (state == AMSC_CONV || state == AMSC_CAL) begin
			phase_cnt <= phase_cnt + CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// continuous alignment tracking
	// ------------------------------------------------------------
	// cycles since the last evaluated align edge
	always_ff @(posedge clk) begin
		if (!rst_n || state != AMSC_CONV) begin
			edge_cnt <= '0;
		end else if (align_eval) begin
			edge_cnt <= CNT_W'(1);
		end else if (edge_cnt != '1) begin
			edge_cnt <= edge_cnt + CNT_W'(1);
		end
	end

	// reference interval, cleared whenever conversions (re)start
	// a restart in continuous mode keeps it until conversions stop
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset || state != AMSC_CONV || cmd_convert) begin
			interval_ref <= '0;
			ref_valid    <= 1'b0;
		end else if (align_eval && !ref_valid) begin
			interval_ref <= edge_cnt; // R3
			ref_valid    <= 1'b1; // R3
		end
	end

	// first result marks the start of edge evaluation
	always_ff @(posedge clk) begin
		if (!rst_n || state != AMSC_CONV || cmd_convert || restart) begin
			first_result_seen <= 1'b0; // R5
		end else if (conv_done) begin
			first_result_seen <= 1'b1; // R6
		end
	end

	// ------------------------------------------------------------
	// result and ready flag
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			result         <= '0;
			result_ready_n <= 1'b1;
		end else if (conv_done) begin
			result         <= sample_data;
			result_ready_n <= 1'b0; // R17
		end else if (result_read) begin
			result_ready_n <= 1'b1; // R17
		end
	end

	// ------------------------------------------------------------
	// configuration register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n || soft_reset) begin
			control_reg_a <= CONTROL_RESET; // R16
		end else if (wr_control) begin
			control_reg_a <= reg_wdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// interrupts: set wins over write-one-to-clear
	// ------------------------------------------------------------
	assign aborted = (state == AMSC_CONV || state == AMSC_CAL) &&
	                 (next_state == AMSC_STANDBY ||
	                  next_state == AMSC_SLEEP) && !cal_done;
	assign irq_events = {aborted, cal_done, restart, conv_done};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= irq_events |
			              (irq_status & ~(is_write(ADDR_IRQ_STATUS) ?
			                              reg_wdata[IRQ_W-1:0] : '0));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_mask <= '0;
		end else if (is_write(ADDR_IRQ_MASK)) begin
			irq_mask <= reg_wdata[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ------------------------------------------------------------
	// read port: data in the cycle after the strobe
	// ------------------------------------------------------------
	// zero outside that cycle, so a stale word never looks like an answer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CONTROL_REG_A: reg_rdata <= {24'h0, control_reg_a};
				ADDR_STATUS:        reg_rdata <= {27'h0, !result_ready_n,
				                        ref_valid, first_result_seen,
				                        2'(state)};
				ADDR_IRQ_STATUS:    reg_rdata <= {28'h0, irq_status};
				ADDR_IRQ_MASK:      reg_rdata <= {28'h0, irq_mask};
				ADDR_RESULT:        reg_rdata <= {8'h0, result};
				ADDR_INTERVAL:      reg_rdata <= {8'h0, interval_ref};
				default:            reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// state outputs
	// ------------------------------------------------------------
	// decoded straight from the state register
	assign low_power_idle = (state == AMSC_STANDBY) || (state == AMSC_SLEEP);
	assign converting     = (state == AMSC_CONV);
	assign calibrating    = (state == AMSC_CAL);
endmodule // amsc_mode_ctrl

// [tb/amsc_host_far.sv]
// amsc_host_far: far-side model feeding align requests and sample words
// assumes the bench pulses fire for one cycle at a rising clock edge
`timescale 1ns/1ps
module amsc_host_far
	import amsc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        fire,
	input  wire logic [23:0] word,
	output logic             align_pin,
	output logic [23:0]      sample_data
);
	logic p0 = 1'b0;
	logic p1 = 1'b0;

	// align request stretched to a two-cycle level, delay fixed
	always @(posedge clk) begin
		p0 <= fire;
		p1 <= p0;
	end
	assign align_pin = p0 | p1;
	// converter front end: steady word chosen by the bench
	assign sample_data = word;
endmodule // amsc_host_far

// [tb/amsc_mode_ctrl_sva.sv]
// amsc_mode_ctrl_sva: port checks of the converter mode controller
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module amsc_mode_ctrl_sva
	import amsc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        reset_pin_n,
	input wire logic        align_pin,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [23:0] sample_data,
	input wire logic        result_ready_n,
	input wire logic        low_power_idle,
	input wire logic        converting,
	input wire logic        calibrating,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic align_q;
	wire  cmd_wr = reg_wr && reg_addr == ADDR_COMMAND;
	wire  a_rise = align_pin && !align_q;
	wire  res_rd = reg_rd && reg_addr == ADDR_RESULT;

	// previous align level for edge detection
	always_ff @(posedge clk) begin
		align_q <= align_pin;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_reset_state: assert property (disable iff (1'b0)
		!rst_n |=> low_power_idle && result_ready_n && !irq)
		else $error("reset left the block active");
	chk_pin_reset: assert property (
		!reset_pin_n |=> low_power_idle && result_ready_n)
		else $error("reset pin did not return to standby");
	chk_align_idle: assert property (
		a_rise && low_power_idle && !reg_wr |=> low_power_idle[*2])
		else $error("align left the idle state");
	chk_align_cal: assert property (
		a_rise && calibrating && !reg_wr |=> calibrating[*2])
		else $error("align disturbed calibration");
	chk_cmd_stay: assert property (
		cmd_wr && reg_wdata[3:0] == 4'h0 && low_power_idle
		|=> low_power_idle)
		else $error("bare command left the idle state");
	chk_cmd_stop: assert property (
		cmd_wr && !reg_wdata[CMD_CONVERT_BIT] && !low_power_idle
		|=> low_power_idle)
		else $error("command write did not stop activity");
	chk_convert_go: assert property (
		cmd_wr && reg_wdata[CMD_CONVERT_BIT]
		&& !reg_wdata[CMD_RESET_BIT] && reset_pin_n |=> converting)
		else $error("convert command did not start conversion");
	chk_ready_hold: assert property (
		!result_ready_n && !reg_rd && !reg_wr && reset_pin_n
		|=> !result_ready_n)
		else $error("result ready dropped before a read");
	chk_ready_read: assert property (
		!result_ready_n && res_rd |=> result_ready_n)
		else $error("result ready stayed low after read");
	chk_ready_src: assert property (
		$fell(result_ready_n) |-> $past(converting))
		else $error("result ready without conversion");
	cov_conv_align: cover property (converting && a_rise);
	cov_result: cover property ($fell(result_ready_n));
	cov_cal_write: cover property (calibrating && cmd_wr);
endmodule // amsc_mode_ctrl_sva

bind amsc_mode_ctrl amsc_mode_ctrl_sva chk_u (
	.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
	.align_pin(align_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sample_data(sample_data), .result_ready_n(result_ready_n),
	.low_power_idle(low_power_idle), .converting(converting),
	.calibrating(calibrating), .irq(irq));

// [tb/tb.sv]
// tb: self-checking bench of the converter mode controller
// assumes the package, the design and the far-side model compile first
`timescale 1ns/1ps
module tb;
	import amsc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reset_pin_n = 1'b1;
	logic        fire = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [23:0] word = 24'h0;
	logic [31:0] reg_rdata, rd_q;
	logic [23:0] sample_data;
	logic        align_pin, result_ready_n, low_power_idle;
	logic        converting, calibrating, irq;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          m_state = 0;
	int          cyc = 0;
	int          t_al, ref_i, t_cv;
	logic [23:0] exp_q[$];

	// clock and free cycle count
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	amsc_mode_ctrl dut_u (.clk(clk), .rst_n(rst_n),
		.reset_pin_n(reset_pin_n), .align_pin(align_pin),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample_data(sample_data), .result_ready_n(result_ready_n),
		.low_power_idle(low_power_idle), .converting(converting),
		.calibrating(calibrating), .irq(irq));
	amsc_host_far host_u (.clk(clk), .fire(fire), .word(word),
		.align_pin(align_pin), .sample_data(sample_data));

	// ----------------------------------------
	// bus, model and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// model state against status field and state outputs
	task automatic st_chk();
		rd(ADDR_STATUS);
		cmp(32'(m_state), {30'h0, rd_q[1:0]});
		cmp({29'h0, m_state < 2, m_state == 3, m_state == 2},
			{29'h0, low_power_idle, converting, calibrating});
	endtask
	task automatic cmd(input logic [31:0] d, input int ns);
		wr(ADDR_COMMAND, d);
		m_state = ns;
		st_chk();
	endtask
	task automatic al(input int t);
		do @(posedge clk); while (cyc < t);
		fire <= 1'b1;
		t_al = cyc;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	task automatic wait_rdy();
		for (int k = 0; k < CONV_CYCLES + 100; k++) begin
			if (result_ready_n === 1'b0) break;
			@(posedge clk);
		end
		cmp(32'h0, {31'h0, result_ready_n});
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// watchdog sized above the roughly 56000 cycles of the tests
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		print_verdict();
	end

	// main sequence
	initial begin
		void'($urandom(32'h933B));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CONTROL_REG_A);
		cmp({24'h0, CONTROL_RESET}, rd_q);
		rd(4'hF);
		cmp(32'h0, rd_q);
		st_chk();
		done("reset");
		al(cyc);
		st_chk();
		cmd(32'h0, 0);
		wr(ADDR_CONTROL_REG_A, {30'h0, PD_SLEEP});
		cmd(32'h2, 1);
		cmd(32'h0, 1);
		cmd(32'h1, 3);
		cmd(32'h0, 0);
		done("idle states");
		@(posedge clk);
		word <= 24'($urandom());
		cmd(32'h1, 3);
		repeat (6000) @(posedge clk);
		cmd(32'h1, 3);
		repeat (8000) @(posedge clk);
		cmp(32'h1, {31'h0, result_ready_n});
		exp_q.push_back(word);
		wait_rdy();
		rd(ADDR_RESULT);
		cmp({8'h0, exp_q.pop_front()}, rd_q);
		cmp(32'h1, {31'h0, result_ready_n});
		done("conversion");
		wr(ADDR_CONTROL_REG_A, {30'h0, PD_STANDBY});
		cmd(32'h4, 0);
		cmd(32'h4, 2);
		al(cyc);
		st_chk();
		cmd(32'h0, 0);
		cmd(32'h4, 2);
		cmd(32'h1, 3);
		done("calibration");
		wr(ADDR_IRQ_STATUS, 32'hF);
		wr(ADDR_IRQ_MASK, 32'h0);
		al(cyc);
		rd(ADDR_IRQ_STATUS);
		cmp(32'h2, rd_q & 32'h2);
		cmp(32'h0, {31'h0, irq});
		wr(ADDR_IRQ_MASK, 32'h2);
		cmp(32'h1, {31'h0, irq});
		wr(ADDR_IRQ_STATUS, 32'h2);
		cmp(32'h0, {31'h0, irq});
		st_chk();
		done("pulse align");
		wr(ADDR_CONTROL_REG_A, 32'h1);
		@(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_pin_n <= 1'b1;
		m_state = 0;
		st_chk();
		rd(ADDR_CONTROL_REG_A);
		cmp({24'h0, CONTROL_RESET}, rd_q);
		done("pin reset");
		wr(ADDR_CONTROL_REG_A, 32'h6);
		wr(ADDR_COMMAND, 32'h1);
		t_cv = cyc;
		m_state = 3;
		st_chk();
		wr(ADDR_IRQ_STATUS, 32'hF);
		al(cyc);
		wait_rdy();
		rd(ADDR_IRQ_STATUS);
		cmp(32'h0, rd_q & 32'h2);
		rd(ADDR_STATUS);
		cmp(32'h0, rd_q & 32'h8);
		al(cyc);
		rd(ADDR_INTERVAL);
		ref_i = int'(rd_q);
		cmp(32'(t_al + 2 - t_cv), rd_q);
		rd(ADDR_STATUS);
		cmp(32'h8, rd_q & 32'h8);
		al(t_al + ref_i + 1);
		rd(ADDR_IRQ_STATUS);
		cmp(32'h0, rd_q & 32'h2);
		al(t_al + ref_i + 2);
		rd(ADDR_IRQ_STATUS);
		cmp(32'h2, rd_q & 32'h2);
		done("continuous align");
		print_verdict();
	end
endmodule // tb
